// ===== design/sram_host_pkg.sv
// Package with the constants, timing figures and state encoding of the static memory host.
// Overview of operation
// - The host times write data setup and hold to the edge that ends the write.
// - The host does not drive the data lines while the memory may still be driving them.
// - A strobe-controlled write pulse lasts at least the strobe-to-float time plus data setup.
// - The host waits at least 100.0 us after power is stable before the first access.
package sram_host_pkg;

	// Pin widths of the memory.
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;

	// Clock and documented times, each in its own unit.
	localparam real CLK_PERIOD_NS            = 50.0;
	localparam real ADDRESS_ACCESS_TIME_NS   = 15.0;
	localparam real STROBE_TO_FLOAT_TIME_NS  = 8.0;
	localparam real WRITE_DATA_SETUP_TIME_NS = 8.0;
	localparam real POWER_UP_WAIT_US         = 100.0;

	// Least whole number of clock cycles that covers a time in ns, never below one.
	function automatic int min_cycles(real t_ns);
		int n;
		n = 1;
		while (n * CLK_PERIOD_NS < t_ns)
			n = n + 1;
		return n;
	endfunction

	// Cycle counts derived from the times above.
	localparam int ACCESS_CYC    = min_cycles(ADDRESS_ACCESS_TIME_NS);
	localparam int PULSE_CYC     = min_cycles(STROBE_TO_FLOAT_TIME_NS + WRITE_DATA_SETUP_TIME_NS);
	localparam int POWER_UP_CYC  = min_cycles(POWER_UP_WAIT_US * 1000.0);
	localparam int SYNC_STAGES   = 2;
	localparam int READ_WAIT_CYC = ACCESS_CYC + SYNC_STAGES;

	// Counter widths.
	localparam int CNT_W     = 4;
	localparam int POWER_CNT_W = 12;

	// Pin levels after reset: memory deselected, strobes high, data released.
	localparam logic PRIMARY_SELECT_N_RST = 1'h1;
	localparam logic SECONDARY_SELECT_RST = 1'h0;
	localparam logic STROBE_N_RST         = 1'h1;
	localparam logic DQ_OE_N_RST          = 1'h1;

	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE     = 6'h01,
		ST_RD_WAIT  = 6'h02,
		ST_TURN     = 6'h04,
		ST_WR_SETUP = 6'h08,
		ST_WR_PULSE = 6'h10,
		ST_WR_HOLD  = 6'h20
	} state_e;

endpackage

// ===== design/powerup_timer.sv
// Counter that holds off memory accesses until the power-up wait has passed.
`timescale 1ns/1ps

module powerup_timer #(
	parameter int CYCLES = sram_host_pkg::POWER_UP_CYC
) (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic rst,
	// Wait finished.
	output logic      done
);

	localparam int W = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} timer_s;

	timer_s q;
	timer_s n;

	// Count up once after reset and latch done; it never falls again until reset.
	always_comb
	begin
		n = q;
		if (rst)
		begin
			n.cnt  = '0;
			n.done = 1'h0;
		end
		else if (!q.done)
		begin
			if (q.cnt == W'(CYCLES - 1))
				n.done = 1'h1;
			else
				n.cnt = q.cnt + W'(1);
		end
	end

	// State register.
	always_ff @(posedge ref_clk)
	begin
		q <= n;
	end

	assign done = q.done;

endmodule

// ===== design/sram_host_ctrl.sv
// Host sequencer that drives an asynchronous static memory with error flag through its pins.
`timescale 1ns/1ps

module sram_host_ctrl #(
	parameter int ADDR_W          = sram_host_pkg::ADDR_W,
	parameter int DATA_W          = sram_host_pkg::DATA_W,
	parameter int POWER_UP_CYCLES = sram_host_pkg::POWER_UP_CYC
) (
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// User request.
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   req_ready,
	// User response.
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	output logic                   rsp_corrected,
	// Memory control pins.
	output logic                   primary_select_n,
	output logic                   secondary_select,
	output logic                   out_enable_n,
	output logic                   write_strobe_n,
	output logic [ADDR_W-1:0]      mem_addr,
	// Memory data pins and error flag.
	input  wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   dq_oe_n,
	input  wire logic              err_i
);

	localparam int CW = sram_host_pkg::CNT_W;
	localparam int PW = sram_host_pkg::POWER_CNT_W;

	typedef struct packed {
		sram_host_pkg::state_e state;
		logic [CW-1:0]         cnt;
		logic                  ready;
		logic                  psel_n;
		logic                  ssel;
		logic                  oe_n;
		logic                  we_n;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     dq_o;
		logic                  dq_oe_n;
		logic [DATA_W-1:0]     dq_s1;
		logic [DATA_W-1:0]     dq_s2;
		logic                  err_s1;
		logic                  err_s2;
		logic                  rsp_valid;
		logic [DATA_W-1:0]     rdata;
		logic                  rerr;
		logic [PW-1:0]         age;
	} ctrl_s;

	ctrl_s q;
	ctrl_s n;
	logic  pwr_ok;

	// Holds every access back until the power-up wait is over.
	powerup_timer #(
		.CYCLES (POWER_UP_CYCLES)
	) u_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.done    (pwr_ok)
	);

	// Next state. Everything, including the pin synchronisers, lives in one struct.
	always_comb
	begin
		n           = q;
		n.rsp_valid = 1'h0;
		// Data and error pins pass two flops; only the second stage is used below.
		n.dq_s1     = dq_i;
		n.dq_s2     = q.dq_s1;
		n.err_s1    = err_i;
		n.err_s2    = q.err_s1;
		if (q.age != '1)
			n.age = q.age + PW'(1);
		if (rst)
		begin
			n.state   = sram_host_pkg::ST_IDLE;
			n.cnt     = '0;
			n.ready   = 1'h0;
			n.psel_n  = sram_host_pkg::PRIMARY_SELECT_N_RST;
			n.ssel    = sram_host_pkg::SECONDARY_SELECT_RST;
			n.oe_n    = sram_host_pkg::STROBE_N_RST;
			n.we_n    = sram_host_pkg::STROBE_N_RST;
			n.addr    = '0;
			n.dq_o    = '0;
			n.dq_oe_n = sram_host_pkg::DQ_OE_N_RST;
			n.dq_s1   = '0;
			n.dq_s2   = '0;
			n.err_s1  = 1'h0;
			n.err_s2  = 1'h0;
			n.rdata   = '0;
			n.rerr    = 1'h0;
			n.age     = '0;
		end
		else
		begin
			case (q.state)
				sram_host_pkg::ST_IDLE:
				begin
					n.ready = pwr_ok;
					if (req_valid && q.ready)
					begin
						n.ready  = 1'h0;
						n.addr   = req_addr;
						n.psel_n = 1'h0;
						n.ssel   = 1'h1;
						if (req_write)
						begin
							// Output enable stays high so the memory never drives during a write.
							n.dq_o    = req_wdata;
							n.dq_oe_n = 1'h0;
							n.state   = sram_host_pkg::ST_WR_SETUP;
						end
						else
						begin
							n.oe_n  = 1'h0;
							n.cnt   = CW'(sram_host_pkg::READ_WAIT_CYC - 1);
							n.state = sram_host_pkg::ST_RD_WAIT;
						end
					end
				end
				sram_host_pkg::ST_RD_WAIT:
				begin
					if (q.cnt == '0)
					begin
						// Error flag is only meaningful here; elsewhere the pin floats.
						n.rdata     = q.dq_s2;
						n.rerr      = q.err_s2;
						n.rsp_valid = 1'h1;
						n.oe_n      = 1'h1;
						n.psel_n    = 1'h1;
						n.ssel      = 1'h0;
						n.state     = sram_host_pkg::ST_TURN;
					end
					else
						n.cnt = q.cnt - CW'(1);
				end
				sram_host_pkg::ST_TURN:
				begin
					// One idle cycle lets the memory release the bus before we may drive it.
					n.ready = pwr_ok;
					n.state = sram_host_pkg::ST_IDLE;
				end
				sram_host_pkg::ST_WR_SETUP:
				begin
					// Data has stood a full cycle before the strobe falls.
					n.we_n  = 1'h0;
					n.cnt   = CW'(sram_host_pkg::PULSE_CYC - 1);
					n.state = sram_host_pkg::ST_WR_PULSE;
				end
				sram_host_pkg::ST_WR_PULSE:
				begin
					if (q.cnt == '0)
					begin
						// The strobe ends the write while select and data are still held.
						n.we_n  = 1'h1;
						n.state = sram_host_pkg::ST_WR_HOLD;
					end
					else
						n.cnt = q.cnt - CW'(1);
				end
				sram_host_pkg::ST_WR_HOLD:
				begin
					// Data and select held one cycle past the strobe edge for hold time.
					n.dq_oe_n   = 1'h1;
					n.psel_n    = 1'h1;
					n.ssel      = 1'h0;
					n.rerr      = 1'h0;
					n.rsp_valid = 1'h1;
					n.ready     = pwr_ok;
					n.state     = sram_host_pkg::ST_IDLE;
				end
				default:
				begin
					n.state = sram_host_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// State register with synchronous reset folded into the next-state logic.
	always_ff @(posedge ref_clk)
	begin
		q <= n;
	end

	// All outputs come straight from the state register.
	assign req_ready        = q.ready;
	assign rsp_valid        = q.rsp_valid;
	assign rsp_rdata        = q.rdata;
	assign rsp_corrected    = q.rerr;
	assign primary_select_n = q.psel_n;
	assign secondary_select = q.ssel;
	assign out_enable_n     = q.oe_n;
	assign write_strobe_n   = q.we_n;
	assign mem_addr         = q.addr;
	assign dq_o             = q.dq_o;
	assign dq_oe_n          = q.dq_oe_n;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// No select before the power-up wait has elapsed since reset.
	property p_power_wait;
		!primary_select_n |-> (int'(q.age) >= POWER_UP_CYCLES);
	endproperty
	a_power_wait:
	assert property (p_power_wait) else $error("memory selected before power-up wait");

	// We drive data only after output enable has been high for at least a cycle.
	property p_no_contention;
		!dq_oe_n |-> (out_enable_n && $past(out_enable_n));
	endproperty
	a_no_contention:
	assert property (p_no_contention) else $error("data driven while memory may drive");

	// Strobe write: setup cycle, pulse, then strobe rises with data and select still held.
	sequence s_wr_pulse;
		(!write_strobe_n && !dq_oe_n && !primary_select_n)[*1];
	endsequence
	sequence s_wr_end;
		write_strobe_n && !dq_oe_n && !primary_select_n && secondary_select;
	endsequence
	property p_write_shape;
		$fell(write_strobe_n) |-> !$past(dq_oe_n) ##0 s_wr_pulse ##1 s_wr_end;
	endproperty
	a_write_shape:
	assert property (p_write_shape) else $error("write strobe shape or data hold wrong");

	// Data released exactly one cycle after the strobe edge that ended the write.
	property p_write_hold;
		$rose(write_strobe_n) |=> dq_oe_n && primary_select_n;
	endproperty
	a_write_hold:
	assert property (p_write_hold) else $error("write data hold not one cycle");

	// Strobe low only while selected with output enable high.
	property p_strobe_sel;
		!write_strobe_n |-> (!primary_select_n && secondary_select && out_enable_n);
	endproperty
	a_strobe_sel:
	assert property (p_strobe_sel) else $error("strobe low outside a selected write");

	// A read answers with the synchronised pins after the access wait.
	sequence s_rd_start;
		$fell(out_enable_n) && !primary_select_n;
	endsequence
	property p_read_answer;
		s_rd_start |-> ##3 (rsp_valid && rsp_corrected == $past(q.err_s2) && out_enable_n);
	endproperty
	a_read_answer:
	assert property (p_read_answer) else $error("read answer not at expected cycle");

endmodule

// ===== verif/sram_ecc_model.sv
// Behavioural model of the error-correcting static memory seen by the host.
`timescale 1ns/1ps

module sram_ecc_model #(
	parameter real        ACCESS_NS = 15.0,
	parameter logic [7:0] BLANK     = 8'h5A
) (
	// Control pins.
	input  wire logic        primary_select_n,
	input  wire logic        secondary_select,
	input  wire logic        out_enable_n,
	input  wire logic        write_strobe_n,
	input  wire logic [20:0] addr,
	// Data pins and error flag.
	input  wire logic [7:0]  data_in,
	output logic [7:0]       data_out,
	output logic             data_drive,
	output logic             err_out
);
	logic [7:0] store [int];
	bit         flawed [int];
	wire        sel_n   = !(!primary_select_n && secondary_select);
	wire        writing = !sel_n && !write_strobe_n;
	wire        reading = !sel_n && !out_enable_n && write_strobe_n;
	wire        settled;

	// The array takes the byte when the overlap ends, whichever pin ends it.
	always @(negedge writing)
	begin
		store[addr] = data_in;
		flawed.delete(addr);
	end

	// Outputs appear only an access time after the read conditions; they drop at once.
	assign #(ACCESS_NS) settled = reading;
	assign data_drive = reading && settled;

	// Reads correct the byte but never rewrite the array, so a flaw stays until a write.
	// The list is explicit because array contents are not reliably part of an implicit one.
	always @(addr or reading or writing)
	begin
		data_out = store.exists(addr) ? store[addr] : BLANK;
		err_out  = flawed.exists(addr);
	end

	// Lets the bench plant a single-bit flaw at one word.
	task automatic mark_flaw(input logic [20:0] a);
		flawed[a] = 1'h1;
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the static memory host sequencer.
`timescale 1ns/1ps

module testbench;
	localparam int         PU    = 8;
	localparam logic [7:0] BLANK = 8'h5A;
	typedef struct {logic wr; logic [7:0] data; logic corr; int cyc;} note_s;
	logic        ref_clk, rst, req_valid, req_write, req_ready, rsp_valid, rsp_corrected;
	logic [20:0] req_addr, mem_addr, a;
	logic [7:0]  req_wdata, rsp_rdata, dq_o, dq_i, mem_dq, d, float_pat;
	logic        primary_select_n, secondary_select, out_enable_n, write_strobe_n;
	logic        dq_oe_n, err_i, mem_drive, mem_err;
	int          failures, total_checks, cyc, low_cnt, seed, i;
	note_s       notes[$];
	note_s       note;
	logic [7:0]  shadow [int];
	bit          flaw [int];

	sram_host_ctrl #(.POWER_UP_CYCLES(PU)) i_sram_host_ctrl (.ref_clk(ref_clk), .rst(rst),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_corrected(rsp_corrected),
		.primary_select_n(primary_select_n), .secondary_select(secondary_select),
		.out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n), .mem_addr(mem_addr),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .err_i(err_i));
	sram_ecc_model #(.BLANK(BLANK)) i_sram_ecc_model (.primary_select_n(primary_select_n),
		.secondary_select(secondary_select), .out_enable_n(out_enable_n),
		.write_strobe_n(write_strobe_n), .addr(mem_addr), .data_in(dq_i),
		.data_out(mem_dq), .data_drive(mem_drive), .err_out(mem_err));

	// Undriven lines show a pattern that moves every cycle, so a stale value never passes.
	assign dq_i  = !dq_oe_n ? dq_o : (mem_drive ? mem_dq : float_pat);
	assign err_i = mem_drive ? mem_err : float_pat[0];

	// Clock, cycle count and float pattern.
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc       <= cyc + 1;
		float_pat <= float_pat + 8'h01;
	end

	// Counts a comparison and reports a difference.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("Counts: %0d failures in %0d checks", failures, total_checks);
		if (failures == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Resets, then measures how long the host holds off its first access.
	task automatic power_up();
		int n;
		rst = 1'h1;
		repeat (16) @(negedge ref_clk);
		rst = 1'h0;
		n = 0;
		while (req_ready !== 1'h1 && n < 100)
		begin
			@(negedge ref_clk);
			n++;
		end
		check("power-up wait", n, PU + 1);
	endtask

	// Issues one request at a falling edge and notes the answer it must bring.
	task automatic access(input logic wr, input logic [20:0] ad, input logic [7:0] dt);
		int n;
		n = 0;
		while (req_ready !== 1'h1 && n < 50)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 50)
		begin
			check("ready wait", 0, 1);
			stop_test();
		end
		req_valid = 1'h1;
		req_write = wr;
		req_addr  = ad;
		req_wdata = dt;
		if (wr)
		begin
			shadow[ad] = dt;
			flaw.delete(ad);
		end
		notes.push_back('{wr, shadow.exists(ad) ? shadow[ad] : BLANK, !wr && flaw.exists(ad), cyc + 1});
		@(negedge ref_clk);
		req_valid = 1'h0;
	endtask

	// Takes the oldest note whenever a response pulse shows.
	always @(negedge ref_clk)
	begin
		if (rsp_valid === 1'h1 && notes.size() == 0)
			check("unexpected response", 1, 0);
		else if (rsp_valid === 1'h1)
		begin
			note = notes.pop_front();
			check("response latency", cyc - note.cyc, 3);
			check("error flag", rsp_corrected, note.corr);
			if (!note.wr)
				check("read data", rsp_rdata, note.data);
		end
	end

	// Pin discipline: no contention, strobe only under select with data, pulse long enough.
	always @(negedge ref_clk)
	begin
		if (!dq_oe_n && mem_drive)
			check("bus contention", 1, 0);
		if (!write_strobe_n && (primary_select_n || !secondary_select || dq_oe_n))
			check("strobe outside select", 1, 0);
		if (!write_strobe_n)
			low_cnt++;
		else if (low_cnt != 0)
		begin
			check("strobe width", low_cnt >= sram_host_pkg::PULSE_CYC, 1);
			low_cnt = 0;
		end
	end

	// A hang is cut short here.
	initial
	begin
		repeat (20000) @(negedge ref_clk);
		check("timeout", 0, 1);
		stop_test();
	end

	// Main sequence.
	initial
	begin
		ref_clk = 1'h0; req_valid = 1'h0; req_write = 1'h0;
		req_addr = 21'h000000; req_wdata = 8'h00; float_pat = 8'h00;
		cyc = 0; low_cnt = 0; failures = 0; total_checks = 0; seed = 79;
		power_up();
		// Boundary addresses, then random traffic back to back.
		access(1'h1, 21'h000000, 8'h3C);
		access(1'h1, 21'h1FFFFF, 8'hC3);
		access(1'h0, 21'h000000, 8'h00);
		access(1'h0, 21'h1FFFFF, 8'h00);
		for (i = 0; i < 12; i++)
		begin
			a = 21'($random(seed));
			d = 8'($random(seed));
			access(1'h1, a, d);
			access(1'h0, a, 8'h00);
		end
		// A planted flaw is flagged on every read until a write replaces the word.
		i_sram_ecc_model.mark_flaw(21'h000ABC);
		flaw[21'h000ABC] = 1'h1;
		access(1'h0, 21'h000ABC, 8'h00);
		access(1'h0, 21'h000ABC, 8'h00);
		access(1'h1, 21'h000ABC, 8'h11);
		access(1'h0, 21'h000ABC, 8'h00);
		// A request raised while busy must leave no trace.
		access(1'h1, 21'h000123, 8'hE1);
		@(negedge ref_clk);
		req_valid = 1'h1; req_write = 1'h1; req_addr = 21'h000123; req_wdata = 8'h1E;
		@(negedge ref_clk);
		req_valid = 1'h0;
		access(1'h0, 21'h000123, 8'h00);
		// Reset again once idle, and run one more pair.
		repeat (8) @(negedge ref_clk);
		power_up();
		access(1'h1, 21'h0F0F0F, 8'hA7);
		access(1'h0, 21'h0F0F0F, 8'h00);
		repeat (8) @(negedge ref_clk);
		check("responses outstanding", notes.size(), 0);
		stop_test();
	end
endmodule
